//--- verilog/tcg_regs.vh
// Operation
// - Enable low stops timer clock, holds reset
// - Enable low ignores timer writes except port registers, reads default
// - Enable high clocks timer, allows access
// - Reset clears peripheral enable register
// - Byte and single-bit writes both accepted
// - Registers undefined when option set, disabled
// - Bit 5 enables event 1 cutoff, channel 1
// - Bit 4 selects pin D1 or event 1
// - Bit 1 enables event 0 cutoff, channel 0
// - Bit 0 high takes capture from event 0
`ifndef TCG_REGS_VH
`define TCG_REGS_VH
// Byte addresses in the peripheral window (low 20 bits of printed address)
`define TCG_ADDR_PER      20'hf007a
`define TCG_ADDR_ELC      20'hf0260
`define TCG_ADDR_BITSET   20'hf0300
`define TCG_ADDR_BITCLR   20'hf0304
`define TCG_ADDR_DEFLT    20'hf0308
// Field positions
`define TCG_PER_EN_BIT    4
`define TCG_PER_RSVD_MASK 8'h0e
`define TCG_ELC_OBE1_BIT  5
`define TCG_ELC_ICE1_BIT  4
`define TCG_ELC_OBE0_BIT  1
`define TCG_ELC_ICE0_BIT  0
`define TCG_ELC_MASK      8'h33
// Reset values
`define TCG_PER_RESET     8'h00
`define TCG_ELC_RESET     8'h00
`define TCG_DEFLT_RESET   8'h00
`endif

//--- verilog/tcg_bit_write.v
`default_nettype none
// Single-bit set or clear on an 8-bit register image
module tcg_bit_write
(
    input  wire [7:0] cur,
    input  wire [2:0] bit_idx,
    input  wire       set_n_clr,
    output reg  [7:0] res
);
    // Touch only the addressed bit
    always @*
    begin
        res = cur;
        res[bit_idx] = set_n_clr;
    end
endmodule // tcg_bit_write
`default_nettype wire

//--- verilog/tcg_capture_mux.v
`default_nettype none
// Capture trigger source and cutoff gating for one channel
module tcg_capture_mux
(
    input  wire pin_in,
    input  wire event_in,
    input  wire event_sel,
    input  wire cutoff_en,
    output wire capture_trig,
    output wire cutoff_req
);
    // Event replaces the pin when selected
    assign capture_trig = event_sel ? event_in : pin_in;
    // Event forces cutoff only when enabled
    assign cutoff_req = cutoff_en & event_in;
endmodule // tcg_capture_mux
`default_nettype wire

//--- verilog/tcg_top.v
// The APB register port was decided locally.
`include "tcg_regs.vh"
`default_nettype none
// Timer clock gate, access gate and event select
module tcg_top
(
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        hs_osc_option_bit,
    input  wire        tmr_sel,
    input  wire        tmr_port_reg,
    input  wire [7:0]  tmr_rdata,
    input  wire        capture_pin_d0,
    input  wire        capture_pin_d1,
    input  wire        event_in0,
    input  wire        event_in1,
    output reg         timer_clock_enable_bit,
    output reg         tmr_clk_en,
    output reg         tmr_rst_n,
    output reg         tmr_wr_allow,
    output reg         capture_d0_trig,
    output reg         capture_d1_trig,
    output reg         cutoff0_req,
    output reg         cutoff1_req
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers and decode
    reg  [7:0]  peripheral_enable_reg_r;
    reg  [7:0]  peripheral_enable_reg_nxt;
    reg  [7:0]  event_select_reg_r;
    reg  [7:0]  event_select_reg_nxt;
    reg  [7:0]  deflt_rd_r;
    reg  [31:0] rdata_nxt;
    reg         err_nxt;
    wire [19:0] addr;
    wire        acc;
    wire        wr;
    wire        en;
    wire [7:0]  bit_res;
    wire        cap0;
    wire        cap1;
    wire        cut0;
    wire        cut1;

    assign addr = paddr[19:0];
    assign acc  = psel & penable & pready;
    assign wr   = acc & pwrite & pstrb[0];
    assign en   = peripheral_enable_reg_r[`TCG_PER_EN_BIT];

    // Single-bit write engine on the enable register
    tcg_bit_write u_bitw
    (
        .cur       (peripheral_enable_reg_r),
        .bit_idx   (pwdata[2:0]),
        .set_n_clr (addr == `TCG_ADDR_BITSET),
        .res       (bit_res)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Write path
    always @*
    begin
        peripheral_enable_reg_nxt = peripheral_enable_reg_r;
        event_select_reg_nxt      = event_select_reg_r;
        if (wr && addr == `TCG_ADDR_PER)
        begin
            peripheral_enable_reg_nxt = pwdata[7:0];
        end
        else if (wr && (addr == `TCG_ADDR_BITSET || addr == `TCG_ADDR_BITCLR))
        begin
            peripheral_enable_reg_nxt = bit_res;
        end
        else if (wr && addr == `TCG_ADDR_ELC && en)
        begin
            // Writes dropped while disabled; unused bits never stored
            event_select_reg_nxt = pwdata[7:0] & `TCG_ELC_MASK;
        end
        if (!en)
        begin
            event_select_reg_nxt = `TCG_ELC_RESET;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path
    always @*
    begin
        rdata_nxt = 32'h0000_0000;
        err_nxt   = 1'b0;
        if (addr == `TCG_ADDR_PER)
        begin
            rdata_nxt[7:0] = peripheral_enable_reg_r;
        end
        else if (addr == `TCG_ADDR_ELC)
        begin
            // Disabled: reads show the default, or unknown-ish image under option
            rdata_nxt[7:0] = en ? event_select_reg_r : deflt_rd_r;
        end
        else if (addr == `TCG_ADDR_BITSET || addr == `TCG_ADDR_BITCLR)
        begin
            rdata_nxt[7:0] = peripheral_enable_reg_r;
        end
        else if (addr == `TCG_ADDR_DEFLT)
        begin
            rdata_nxt[7:0] = deflt_rd_r;
        end
        else
        begin
            err_nxt = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Channel routing
    tcg_capture_mux u_ch0
    (
        .pin_in       (capture_pin_d0),
        .event_in     (event_in0),
        .event_sel    (event_select_reg_r[`TCG_ELC_ICE0_BIT]),
        .cutoff_en    (event_select_reg_r[`TCG_ELC_OBE0_BIT]),
        .capture_trig (cap0),
        .cutoff_req   (cut0)
    );

    tcg_capture_mux u_ch1
    (
        .pin_in       (capture_pin_d1),
        .event_in     (event_in1),
        .event_sel    (event_select_reg_r[`TCG_ELC_ICE1_BIT]),
        .cutoff_en    (event_select_reg_r[`TCG_ELC_OBE1_BIT]),
        .capture_trig (cap1),
        .cutoff_req   (cut1)
    );

    ////////////////////////////////////////////////////////////////////////////
    // State and registered outputs
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            peripheral_enable_reg_r <= `TCG_PER_RESET;
            event_select_reg_r      <= `TCG_ELC_RESET;
            deflt_rd_r              <= `TCG_DEFLT_RESET;
            prdata                  <= 32'h0000_0000;
            pready                  <= 1'b0;
            pslverr                 <= 1'b0;
            timer_clock_enable_bit  <= 1'b0;
            tmr_clk_en              <= 1'b0;
            tmr_rst_n               <= 1'b0;
            tmr_wr_allow            <= 1'b0;
            capture_d0_trig         <= 1'b0;
            capture_d1_trig         <= 1'b0;
            cutoff0_req             <= 1'b0;
            cutoff1_req             <= 1'b0;
        end
        else
        begin
            peripheral_enable_reg_r <= peripheral_enable_reg_nxt;
            event_select_reg_r      <= event_select_reg_nxt;
            // Default read image: zero normally, all ones under the oscillator option
            deflt_rd_r              <= hs_osc_option_bit ? 8'hff : 8'h00;
            // No wait state: ready in the cycle after setup
            pready                  <= psel & ~pready;
            pslverr                 <= psel & ~pready & err_nxt;
            prdata                  <= (psel & ~pready & ~pwrite) ? rdata_nxt : 32'h0000_0000;
            timer_clock_enable_bit  <= peripheral_enable_reg_nxt[`TCG_PER_EN_BIT];
            tmr_clk_en              <= peripheral_enable_reg_nxt[`TCG_PER_EN_BIT];
            tmr_rst_n               <= peripheral_enable_reg_nxt[`TCG_PER_EN_BIT];
            // Port data and direction stay writable while disabled
            tmr_wr_allow            <= tmr_sel & (en | tmr_port_reg);
            capture_d0_trig         <= cap0;
            capture_d1_trig         <= cap1;
            cutoff0_req             <= cut0;
            cutoff1_req             <= cut1;
        end
    end

endmodule // tcg_top
`default_nettype wire

//--- testbench/tcg_checker.sv
`default_nettype none
// Checks gating and cutoff outputs against the enable bit
module tcg_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tmr_sel,
    input wire logic tmr_port_reg,
    input wire logic timer_clock_enable_bit,
    input wire logic tmr_clk_en,
    input wire logic tmr_rst_n,
    input wire logic tmr_wr_allow,
    input wire logic event_in0,
    input wire logic event_in1,
    input wire logic cutoff0_req,
    input wire logic cutoff1_req
);
    wire en = timer_clock_enable_bit;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////
    // Clock gate and timer reset
    property p_off; !en && !$past(en) |-> !tmr_clk_en && !tmr_rst_n; endproperty
    a_off: assert property (p_off) else $error("timer not stopped");
    property p_on; en && $past(en) |-> tmr_clk_en && tmr_rst_n; endproperty
    a_on: assert property (p_on) else $error("timer not running");
    // Access gate
    property p_blk; tmr_sel && !tmr_port_reg && !en ##1 !en |-> !tmr_wr_allow; endproperty
    a_blk: assert property (p_blk) else $error("write let through");
    property p_port; tmr_sel && tmr_port_reg |=> tmr_wr_allow; endproperty
    a_port: assert property (p_port) else $error("port write blocked");
    property p_acc; tmr_sel && en ##1 en |-> tmr_wr_allow; endproperty
    a_acc: assert property (p_acc) else $error("write blocked");
    // Cutoff needs its event and a running timer
    property p_cut0; cutoff0_req |-> $past(event_in0); endproperty
    a_cut0: assert property (p_cut0) else $error("stray cutoff 0");
    property p_cut1; cutoff1_req |-> $past(event_in1); endproperty
    a_cut1: assert property (p_cut1) else $error("stray cutoff 1");
    property p_idle; !en && !$past(en) && !$past(en, 2) |-> !cutoff0_req && !cutoff1_req; endproperty
    a_idle: assert property (p_idle) else $error("cutoff while held");
endmodule // tcg_checker
bind tcg_top tcg_checker u_tcg_checker (.*);
`default_nettype wire

//--- testbench/tcg_event_src.sv
`default_nettype none
// Event router and capture pins
module tcg_event_src (
    input wire logic [3:0] pattern,
    output wire logic      capture_pin_d0,
    output wire logic      capture_pin_d1,
    output wire logic      event_in0,
    output wire logic      event_in1
);
    // Levels follow the bench pattern, which moves only after an edge
    assign {event_in1, event_in0, capture_pin_d1, capture_pin_d0} = pattern;
endmodule // tcg_event_src
`default_nettype wire

//--- testbench/tcg_top_test.sv
`include "tcg_regs.vh"
`default_nettype none
// Bench for clock gate and event select
module tcg_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr, hs_osc_option_bit, tmr_sel, tmr_port_reg, er;
    logic        timer_clock_enable_bit, tmr_clk_en, tmr_rst_n, tmr_wr_allow, cutoff0_req, cutoff1_req;
    logic        capture_pin_d0, capture_pin_d1, event_in0, event_in1, capture_d0_trig, capture_d1_trig;
    logic [31:0] paddr, pwdata, prdata;
    logic [3:0]  pattern, pstrb;
    logic [7:0]  rd;
    int          miscompares, total_checks;
    // Select, {ev1, ev0, pin1, pin0}, {gate, cut1, cut0, cap1, cap0}
    logic [16:0] rows [6] = '{{8'h00, 4'hc, 5'h10}, {8'h00, 4'h3, 5'h13}, {8'hff, 4'hc, 5'h1f},
                              {8'h33, 4'h3, 5'h10}, {8'h01, 4'h6, 5'h13}, {8'h22, 4'hc, 5'h1c}};
    always #4 pclk = ~pclk;
    tcg_top u_tcg_top (.*, .tmr_rdata(8'h00));
    tcg_event_src u_tcg_event_src (.*);
    ////////////////////////////////////////
    // One APB transfer, bounded wait
    task automatic apb(input logic [19:0] a, input logic w, input logic [7:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {12'h000, a};
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
        // A slave that never answers counts as a mismatch
        if (pready !== 1'b1)
            miscompares++;
        rd = prdata[7:0];
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Byte compare
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            miscompares++;
        end
    endtask
    // Verdict
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Watchdog, well beyond the run length
    initial
    begin
        #(4000 * 8);
        miscompares++;
        report_and_stop;
    end
    // Main sequence
    initial
    begin
        {presetn, psel, penable, pwrite, hs_osc_option_bit, tmr_port_reg, paddr, pwdata} = '0;
        {miscompares, total_checks} = '0;
        pattern = 4'hc;
        pstrb = 4'hf;
        tmr_sel = 1'b1;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(`TCG_ADDR_PER, 1'b0, 8'h00);
        chk("enable", `TCG_PER_RESET, rd);
        apb(`TCG_ADDR_ELC, 1'b1, 8'h33);
        apb(`TCG_ADDR_ELC, 1'b0, 8'h00);
        chk("select off", 8'h00, rd);
        hs_osc_option_bit <= 1'b1;
        apb(`TCG_ADDR_ELC, 1'b0, 8'h00);
        chk("image", 8'hff, rd);
        chk("held", 8'h00, {tmr_clk_en, tmr_rst_n, tmr_wr_allow, cutoff0_req, cutoff1_req, 3'b000});
        tmr_port_reg <= 1'b1;
        repeat (2) @(posedge pclk);
        chk("port", 8'h01, {7'h00, tmr_wr_allow});
        $display("disabled test done");
        tmr_port_reg <= 1'b0;
        apb(`TCG_ADDR_PER, 1'b1, 8'h10);
        apb(`TCG_ADDR_BITCLR, 1'b1, 8'h04);
        apb(`TCG_ADDR_PER, 1'b0, 8'h00);
        chk("bit clear", 8'h00, rd);
        apb(`TCG_ADDR_BITSET, 1'b1, 8'h04);
        apb(`TCG_ADDR_PER, 1'b0, 8'h00);
        chk("bit set", 8'h10, rd);
        chk("running", 8'h07, {5'h00, timer_clock_enable_bit, tmr_clk_en, tmr_rst_n});
        apb(20'hf0400, 1'b0, 8'h00);
        chk("unmapped", 8'h01, {7'h00, er});
        $display("enable test done");
        for (int i = 0; i < 6; i++)
        begin
            apb(`TCG_ADDR_ELC, 1'b1, rows[i][16:9]);
            apb(`TCG_ADDR_ELC, 1'b0, 8'h00);
            chk("select", rows[i][16:9] & `TCG_ELC_MASK, rd);
            pattern <= rows[i][8:5];
            repeat (3) @(posedge pclk);
            chk("paths", {3'b000, rows[i][4:0]},
                {3'b000, tmr_wr_allow, cutoff1_req, cutoff0_req, capture_d1_trig, capture_d0_trig});
            $display("row %0d done", i);
        end
        // Write without its low byte strobe is dropped
        pstrb <= 4'h0;
        apb(`TCG_ADDR_PER, 1'b1, 8'h00);
        pstrb <= 4'hf;
        apb(`TCG_ADDR_PER, 1'b0, 8'h00);
        chk("strobe", 8'h10, rd);
        $display("strobe test done");
        // Reset in mid-run clears the enable register again
        presetn <= 1'b0;
        @(posedge pclk);
        chk("in reset", 8'h00, {tmr_clk_en, tmr_rst_n, timer_clock_enable_bit, cutoff0_req, cutoff1_req, pready, 2'b00});
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(`TCG_ADDR_PER, 1'b0, 8'h00);
        chk("enable after reset", `TCG_PER_RESET, rd);
        chk("held after reset", 8'h00, {6'h00, tmr_clk_en, tmr_rst_n});
        $display("reset test done");
        report_and_stop;
    end
endmodule // tcg_top_test
`default_nettype wire
